// [core/hub_power_consts.vh]
/*
 Constants for the hub port power and charging controller: register offsets,
 field positions, reset values, mode codes and timing.
 Assumes inclusion by bare name from files under core/.
*/
`ifndef HUB_POWER_CONSTS_VH
`define HUB_POWER_CONSTS_VH

// Register byte offsets
`define REG_CTRL 4'h0
`define REG_PORT_POWER 4'h4
`define REG_STATUS 4'h8
`define REG_OC_LATCH 4'hC

// Control register fields
`define CTRL_GANGED 0
`define CTRL_BC_EN 1
`define CTRL_AUTO 2
`define CTRL_SEL_LO 4
`define CTRL_SEL_HI 5
`define CTRL_U2_LO 8
`define CTRL_U2_HI 11
`define CTRL_RESET 32'h0000_0002

// Manual charge selection codes
`define SEL_DCP 2'h0
`define SEL_DIVIDER_CHARGE_MODE_1 2'h1
`define SEL_DIVIDER_CHARGE_MODE_2 2'h2
`define SEL_DIVIDER_CHARGE_MODE_3 2'h3

// Charge mode output codes
`define CHG_OFF 3'h0
`define CHG_CDP 3'h1
`define CHG_DCP 3'h2
`define CHG_DIVIDER_CHARGE_MODE_1 3'h3
`define CHG_DIVIDER_CHARGE_MODE_2 3'h4
`define CHG_DIVIDER_CHARGE_MODE_3 3'h5

// Upstream link speed codes
`define SPD_SS 2'h0
`define SPD_HS 2'h1
`define SPD_FS 2'h2
`define SPD_LS 2'h3

// Internal port and billboard placement
`define INT_PORT_NUM 3'h5
`define ALT_MODE_COUNT 2'h1

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Timing: dwell per automatic charging step
`define CLK_MHZ 50
`define CHARGE_STEP_US 100000

`endif

// [core/oc_filter.v]
/*
 Over-current input conditioner: two-flop synchroniser followed by a
 two-sample agreement filter that rejects single-cycle glitches.
 Assumes the raw pin is asynchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none

module oc_filter (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Raw pin, active low
    input wire pin_n,
    // Filtered over-current level, active high
    output reg active
);

reg sync1;
reg sync2;
reg prev;

always @(posedge clk or posedge rst) begin
    if (rst) begin
        sync1 <= 1'b1;
        sync2 <= 1'b1;
        prev <= 1'b1;
        active <= 1'b0;
    end else begin
        sync1 <= pin_n;
        sync2 <= sync1;
        prev <= sync2;
        // Only a level seen on two samples running is believed
        if (sync2 == prev) begin
            active <= ~sync2;
        end
    end
end

endmodule

`default_nettype wire

// [core/hub_port_power_charging_ctrl.v]
/*
 Port power switching, over-current handling, charging mode selection and
 downstream speed gating for a four-port hub, with an AXI4-Lite register slave.
 Assumes upstream state inputs come from logic on clk; over-current pins are
 asynchronous and active low.
*/
`timescale 1ns/100ps
`default_nettype none
`include "hub_power_consts.vh"

// Function
// - Individual mode switches each port's power from its own host request, or every port while a dedicated or divider charge mode is active.
// - Individual mode over-current removes power only from the reporting port.
// - Ganged mode powers every port when any port needs power.
// - Ganged mode keeps shared power on until no port needs it.
// - Ganged mode over-current switches all ports off together.
// - Connected upstream with charging enabled offers charging downstream port mode, except a manually picked divider mode while unconfigured.
// - Unconnected upstream allows dedicated charging mode on downstream ports.
// - Divider charge modes only while upstream unconnected or not configured.
// - Automatic mode steps divider 3, 2, 1, then dedicated charging.
// - High-speed or slower upstream disables SuperSpeed on all downstream ports.
// - Full/low-speed upstream disables SuperSpeed and high-speed downstream.
// - Four external ports plus one internal USB 2.0-only port.
// - Internal port runs high or full speed, matching upstream.
// - Billboard sits on the highest-numbered USB 2.0 downstream port.
// - Billboard reports exactly one alternate mode.
// - Each port may be set USB 2.0-only with SuperSpeed off.
// - Single reference clock drives all logic.
// - Reset returns all registers to defaults; nothing operates meanwhile.
module hub_port_power_charging_ctrl #(
    parameter CHARGE_STEP_CYCLES = `CHARGE_STEP_US * `CLK_MHZ
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // AXI4-Lite write address
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Upstream state
    input wire up_connected,
    input wire up_configured,
    input wire [1:0] up_speed,
    // Power switches and over-current pins
    input wire [3:0] oc_n,
    output reg [3:0] port_power_en,
    // Downstream speed enables
    output reg [3:0] port_ss_en,
    output reg [3:0] port_hs_en,
    output reg int_port_hs,
    // Charging and billboard
    output reg [2:0] charge_mode,
    output wire [2:0] billboard_port,
    output wire [1:0] alt_mode_count
);

localparam ST_IDLE = 5'b00001;
localparam ST_DIVIDER_CHARGE_MODE_3 = 5'b00010;
localparam ST_DIVIDER_CHARGE_MODE_2 = 5'b00100;
localparam ST_DIVIDER_CHARGE_MODE_1 = 5'b01000;
localparam ST_DCP = 5'b10000;

////////////////////////////////////////////////////////////////////////////////
// Over-current conditioning

wire [3:0] oc_level;

genvar gi;
generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_oc
        oc_filter u_oc (
            .clk(clk),
            .rst(rst),
            .pin_n(oc_n[gi]),
            .active(oc_level[gi])
        );
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Register bus

reg [31:0] ctrl;
reg [3:0] host_power;
reg [3:0] oc_latch;
reg [3:0] aw_addr;
reg aw_got;
reg [31:0] w_data;
reg [3:0] w_strb;
reg w_got;

wire ganged = ctrl[`CTRL_GANGED];
wire bc_en = ctrl[`CTRL_BC_EN];
wire auto_mode = ctrl[`CTRL_AUTO];
wire [1:0] charge_sel = ctrl[`CTRL_SEL_HI:`CTRL_SEL_LO];
wire [3:0] usb2_only = ctrl[`CTRL_U2_HI:`CTRL_U2_LO];

assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
assign s_axi_wready = ~w_got & ~s_axi_bvalid;
assign s_axi_arready = ~s_axi_rvalid;

wire do_write = aw_got & w_got & ~s_axi_bvalid;
wire wr_ctrl = do_write & (aw_addr == `REG_CTRL);
wire wr_power = do_write & (aw_addr == `REG_PORT_POWER);
wire wr_oc = do_write & (aw_addr == `REG_OC_LATCH);
wire wr_known = wr_ctrl | wr_power | wr_oc | (aw_addr == `REG_STATUS);

// Over-current levels become sticky; a new event beats a same-cycle clear
wire [3:0] oc_clear = (wr_oc & w_strb[0]) ? w_data[3:0] : 4'h0;
wire [3:0] next_oc_latch = (oc_latch & ~oc_clear) | oc_level;

integer bi;
always @(posedge clk or posedge rst) begin
    if (rst) begin
        ctrl <= `CTRL_RESET;
        host_power <= 4'h0;
        oc_latch <= 4'h0;
        aw_addr <= 4'h0;
        aw_got <= 1'b0;
        w_data <= 32'h0000_0000;
        w_strb <= 4'h0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `RESP_OKAY;
    end else begin
        oc_latch <= next_oc_latch;
        if (s_axi_awvalid & s_axi_awready) begin
            aw_addr <= {s_axi_awaddr[3:2], 2'b00};
            aw_got <= 1'b1;
        end
        if (s_axi_wvalid & s_axi_wready) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            w_got <= 1'b1;
        end
        if (wr_ctrl) begin
            for (bi = 0; bi < 4; bi = bi + 1) begin
                if (w_strb[bi]) begin
                    ctrl[bi*8 +: 8] <= w_data[bi*8 +: 8];
                end
            end
        end
        if (wr_power & w_strb[0]) begin
            host_power <= w_data[3:0];
        end
        if (do_write) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

wire [31:0] status_word = {16'h0000, 2'b00, alt_mode_count, 1'b0, charge_mode,
                           oc_level, port_power_en};

always @(posedge clk or posedge rst) begin
    if (rst) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case ({s_axi_araddr[3:2], 2'b00})
            `REG_CTRL: s_axi_rdata <= ctrl;
            `REG_PORT_POWER: s_axi_rdata <= {28'h0000000, host_power};
            `REG_STATUS: s_axi_rdata <= status_word;
            `REG_OC_LATCH: s_axi_rdata <= {28'h0000000, oc_latch};
            default: begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `RESP_SLVERR;
            end
        endcase
    end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Automatic charging sequence

reg [4:0] chg_state;
reg [4:0] next_chg_state;
reg [31:0] step_count;

// Runs only while upstream is absent; any connect drops back to idle
wire auto_run = bc_en & auto_mode & ~up_connected;
wire step_done = (step_count == CHARGE_STEP_CYCLES - 1);

always @* begin
    next_chg_state = chg_state;
    case (chg_state)
        ST_IDLE: begin
            if (auto_run) begin
                next_chg_state = ST_DIVIDER_CHARGE_MODE_3;
            end
        end
        ST_DIVIDER_CHARGE_MODE_3: begin
            if (!auto_run) begin
                next_chg_state = ST_IDLE;
            end else if (step_done) begin
                next_chg_state = ST_DIVIDER_CHARGE_MODE_2;
            end
        end
        ST_DIVIDER_CHARGE_MODE_2: begin
            if (!auto_run) begin
                next_chg_state = ST_IDLE;
            end else if (step_done) begin
                next_chg_state = ST_DIVIDER_CHARGE_MODE_1;
            end
        end
        ST_DIVIDER_CHARGE_MODE_1: begin
            if (!auto_run) begin
                next_chg_state = ST_IDLE;
            end else if (step_done) begin
                next_chg_state = ST_DCP;
            end
        end
        ST_DCP: begin
            // Final step is held for as long as upstream stays away
            if (!auto_run) begin
                next_chg_state = ST_IDLE;
            end
        end
        default: next_chg_state = ST_IDLE;
    endcase
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        chg_state <= ST_IDLE;
        step_count <= 32'h0000_0000;
    end else begin
        chg_state <= next_chg_state;
        if (next_chg_state != chg_state || chg_state == ST_IDLE || chg_state == ST_DCP) begin
            step_count <= 32'h0000_0000;
        end else begin
            step_count <= step_count + 32'h0000_0001;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Charging mode selection

reg [2:0] next_charge_mode;
reg [2:0] sel_mode;

always @* begin
    case (charge_sel)
        `SEL_DIVIDER_CHARGE_MODE_1: sel_mode = `CHG_DIVIDER_CHARGE_MODE_1;
        `SEL_DIVIDER_CHARGE_MODE_2: sel_mode = `CHG_DIVIDER_CHARGE_MODE_2;
        `SEL_DIVIDER_CHARGE_MODE_3: sel_mode = `CHG_DIVIDER_CHARGE_MODE_3;
        default: sel_mode = `CHG_DCP;
    endcase
end

always @* begin
    next_charge_mode = `CHG_OFF;
    if (!bc_en) begin
        next_charge_mode = `CHG_OFF;
    end else if (up_connected && up_configured) begin
        next_charge_mode = `CHG_CDP;
    end else if (up_connected) begin
        // Not yet configured: manually picked divider modes allowed, dedicated mode is not
        if (!auto_mode && sel_mode != `CHG_DCP) begin
            next_charge_mode = sel_mode;
        end else begin
            next_charge_mode = `CHG_CDP;
        end
    end else if (auto_mode) begin
        case (chg_state)
            ST_DIVIDER_CHARGE_MODE_3: next_charge_mode = `CHG_DIVIDER_CHARGE_MODE_3;
            ST_DIVIDER_CHARGE_MODE_2: next_charge_mode = `CHG_DIVIDER_CHARGE_MODE_2;
            ST_DIVIDER_CHARGE_MODE_1: next_charge_mode = `CHG_DIVIDER_CHARGE_MODE_1;
            ST_DCP: next_charge_mode = `CHG_DCP;
            default: next_charge_mode = `CHG_OFF;
        endcase
    end else begin
        next_charge_mode = sel_mode;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Power switching and speed gating

// Charging without a host needs VBUS on every port
wire charge_power = (next_charge_mode != `CHG_OFF) & (next_charge_mode != `CHG_CDP);
wire [3:0] power_req = host_power | {4{charge_power}};
reg [3:0] next_power;

always @* begin
    if (ganged) begin
        // Shared switch: on while any port asks, off for all on any fault
        next_power = {4{(|power_req) & ~(|next_oc_latch)}};
    end else begin
        next_power = power_req & ~next_oc_latch;
    end
end

wire ss_ok = (up_speed == `SPD_SS);
wire hs_ok = (up_speed == `SPD_SS) | (up_speed == `SPD_HS);

always @(posedge clk or posedge rst) begin
    if (rst) begin
        port_power_en <= 4'h0;
        port_ss_en <= 4'h0;
        port_hs_en <= 4'h0;
        int_port_hs <= 1'b0;
        charge_mode <= `CHG_OFF;
    end else begin
        port_power_en <= next_power;
        port_ss_en <= {4{ss_ok}} & ~usb2_only;
        port_hs_en <= {4{hs_ok}};
        int_port_hs <= hs_ok;
        charge_mode <= next_charge_mode;
    end
end

// Internal USB 2.0 port is number five, highest on the USB 2.0 hub
assign billboard_port = `INT_PORT_NUM;
assign alt_mode_count = `ALT_MODE_COUNT;

endmodule

`default_nettype wire

// [tb/hub_power_props.sv]
/* Port checker for the hub power controller.
 Assumes one clock domain and binding to the top module. */
`timescale 1ns/100ps
`default_nettype none
`include "hub_power_consts.vh"
module hub_power_props #(
    parameter CHARGE_STEP_CYCLES = 20
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Register bus
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // Hub side
    input wire [1:0] up_speed,
    input wire [3:0] oc_n,
    input wire [3:0] port_power_en,
    input wire [3:0] port_ss_en,
    input wire [3:0] port_hs_en,
    input wire int_port_hs,
    input wire [2:0] billboard_port,
    input wire [1:0] alt_mode_count
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_ss_gate: assert property ($past(up_speed) != `SPD_SS |-> port_ss_en == 4'h0)
        else $error("ss on slow link");
    chk_hs_gate: assert property ($past(up_speed) > `SPD_HS |-> port_hs_en == 4'h0 && !int_port_hs)
        else $error("hs on full speed link");
    chk_int_speed: assert property (!$past(rst) |-> int_port_hs == ($past(up_speed) <= `SPD_HS))
        else $error("internal port speed wrong");
    chk_bb_place: assert property (billboard_port == `INT_PORT_NUM && alt_mode_count == `ALT_MODE_COUNT)
        else $error("billboard placement wrong");
    chk_power_reset: assert property ($past(rst) |-> port_power_en == 4'h0)
        else $error("power on out of reset");
    chk_oc_cut: assert property ($fell(oc_n[0]) |-> ##[1:8] !port_power_en[0])
        else $error("power kept on over-current");
    chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("no write response");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read response");
    chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read response dropped");
endmodule
bind hub_port_power_charging_ctrl hub_power_props #(.CHARGE_STEP_CYCLES(CHARGE_STEP_CYCLES)) chk (
    .clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .up_speed(up_speed), .oc_n(oc_n),
    .port_power_en(port_power_en), .port_ss_en(port_ss_en), .port_hs_en(port_hs_en),
    .int_port_hs(int_port_hs), .billboard_port(billboard_port), .alt_mode_count(alt_mode_count));
`default_nettype wire

// [tb/oc_switch_model.sv]
/* Power switch and over-current sensor model for four ports.
 Assumes the bench asks for shorted loads; idle flags are pulled up. */
`timescale 1ns/100ps
`default_nettype none
module oc_switch_model (
    // Switch enables from the hub
    input wire logic [3:0] power_en,
    // Shorted loads asked for by the bench
    input wire logic [3:0] short_req,
    // Over-current flags, active low
    output wire logic [3:0] oc_n
);
    // A short trips only while fed, so a cut clears the flag
    assign oc_n = ~(power_en & short_req);
endmodule
`default_nettype wire

// [tb/hub_port_power_charging_ctrl_test.sv]
/* Self-checking bench for the hub power controller.
 Assumes the switch model, the bound checker and the constants header. */
`timescale 1ns/100ps
`default_nettype none
`include "hub_power_consts.vh"
module hub_port_power_charging_ctrl_test;
    localparam STEP = 20;
    logic clk, rst, awv, wv, bready, arv, rready, conn, cfg;
    logic [3:0] awaddr, araddr, shorts, req;
    logic [31:0] wdata, seed, rv;
    logic [1:0] spd;
    logic [2:0] prev, e;
    logic [2:0] seq [4] = '{`CHG_DIVIDER_CHARGE_MODE_3, `CHG_DIVIDER_CHARGE_MODE_2, `CHG_DIVIDER_CHARGE_MODE_1, `CHG_DCP};
    wire awready, wready, bvalid, arready, rvalid, ih;
    wire [1:0] bresp, rresp, alt;
    wire [31:0] rdata;
    wire [3:0] oc_n, pwr, ss, hs;
    wire [2:0] chg, bbp;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    ////////////////////////////////////////////////////////////////
    hub_port_power_charging_ctrl #(.CHARGE_STEP_CYCLES(STEP)) uut (
        .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .up_connected(conn), .up_configured(cfg),
        .up_speed(spd), .oc_n(oc_n), .port_power_en(pwr), .port_ss_en(ss), .port_hs_en(hs),
        .int_port_hs(ih), .charge_mode(chg), .billboard_port(bbp), .alt_mode_count(alt));
    oc_switch_model sw (.power_en(pwr), .short_req(shorts), .oc_n(oc_n));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    task tally_and_finish;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awv <= 1'b0;
            if (wready) wv <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        cmp(32'(bresp), 32'(`RESP_OKAY));
    endtask
    task rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arv <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        d = rdata;
        cmp(32'(rresp), 32'(`RESP_OKAY));
    endtask
    task settle;
        repeat (3) @(posedge clk);
    endtask
    // Long enough for sync, filter and cut before the short is lifted
    task short(input logic [3:0] m);
        @(posedge clk);
        shorts <= m;
        repeat (10) @(posedge clk);
        shorts <= 4'h0;
        settle();
    endtask
    function logic [8:0] exp_spd(input logic [1:0] s, input logic [3:0] u2);
        exp_spd = {(s == `SPD_SS) ? ~u2 : 4'h0, (s <= `SPD_HS) ? 4'hF : 4'h0, s <= `SPD_HS};
    endfunction
    function logic [2:0] exp_chg(input logic c, input logic g, input logic [1:0] sel);
        exp_chg = (c && (g || sel == `SEL_DCP)) ? `CHG_CDP : `CHG_DCP + {1'b0, sel};
    endfunction
    ////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial begin
        seed = 32'h14E1;
        rst = 1'b1;
        {awv, wv, bready, arv, rready} = 5'h00;
        {awaddr, araddr, wdata, shorts} = 44'h0;
        {conn, cfg, spd} = {2'b11, `SPD_SS};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        cmp(32'(pwr), 32'h0);
        rd(`REG_CTRL, rv);
        cmp(rv, `CTRL_RESET);
        rd(`REG_PORT_POWER, rv);
        cmp(rv, 32'h0);
        wr(`REG_STATUS, 32'hFFFFFFFF);
        rd(`REG_STATUS, rv);
        cmp(rv, {18'h0, `ALT_MODE_COUNT, 1'b0, `CHG_CDP, 8'h0});
        // Port 2 held to USB 2.0
        wr(`REG_CTRL, 32'h0402);
        for (int s = 0; s < 4; s++) begin
            spd <= s[1:0];
            settle();
            cmp(32'({ss, hs, ih}), 32'(exp_spd(s[1:0], 4'h4)));
        end
        spd <= `SPD_SS;
        wr(`REG_CTRL, 32'h2);
        repeat (6) begin
            rv = $random(seed);
            wr(`REG_PORT_POWER, 32'(rv[3:0]));
            settle();
            cmp(32'(pwr), 32'(rv[3:0]));
        end
        wr(`REG_PORT_POWER, 32'hF);
        short(4'h2);
        cmp(32'(pwr), 32'hD);
        rd(`REG_OC_LATCH, rv);
        cmp(rv, 32'h2);
        wr(`REG_OC_LATCH, 32'h2);
        @(posedge clk);
        shorts <= 4'h4;
        @(posedge clk);
        shorts <= 4'h0;
        repeat (10) @(posedge clk);
        cmp(32'(pwr), 32'hF);
        wr(`REG_CTRL, 32'h3);
        for (int i = 0; i < 5; i++) begin
            rv = $random(seed);
            req = (i == 4) ? 4'h0 : rv[3:0];
            wr(`REG_PORT_POWER, 32'(req));
            settle();
            cmp(32'(pwr), (req != 4'h0) ? 32'hF : 32'h0);
        end
        wr(`REG_PORT_POWER, 32'h3);
        short(4'h1);
        cmp(32'(pwr), 32'h0);
        wr(`REG_OC_LATCH, 32'hF);
        settle();
        cmp(32'(pwr), 32'hF);
        wr(`REG_PORT_POWER, 32'h0);
        wr(`REG_CTRL, 32'h0);
        settle();
        cmp(32'(chg), 32'(`CHG_OFF));
        // All 16 connect, configure and manual selection cases: charge mode and port power
        for (int k = 0; k < 16; k++) begin
            conn <= k[3];
            cfg <= k[2];
            wr(`REG_CTRL, {26'h0, k[1:0], 4'h2});
            settle();
            e = exp_chg(k[3], k[2], k[1:0]);
            cmp(32'(chg), 32'(e));
            cmp(32'(pwr), (e == `CHG_CDP) ? 32'h0 : 32'hF);
        end
        wr(`REG_CTRL, 32'h6);
        settle();
        conn <= 1'b0;
        foreach (seq[i]) begin
            prev = chg;
            rv = 32'h0;
            // Sequencer leaves idle one cycle before its first step shows
            while (chg === prev || (i == 0 && chg === `CHG_OFF)) begin
                @(posedge clk);
                rv = rv + 32'h1;
            end
            cmp(32'(chg), 32'(seq[i]));
            if (i > 0) cmp(rv, 32'(STEP));
        end
        repeat (3 * STEP) @(posedge clk);
        cmp(32'(chg), 32'(`CHG_DCP));
        tally_and_finish();
    end
endmodule
`default_nettype wire
